// file: rtl/gdpsr_pkg.sv
// Shared constants, field layouts and types for the protect/sense registers
package gdpsr_pkg;

  // Register addresses on the serial register port
  localparam logic [3:0]  ADDR_OCP_CTRL  = 4'h5;
  localparam logic [3:0]  ADDR_CSA_CTRL  = 4'h6;
  localparam logic [3:0]  ADDR_DRV_CFG   = 4'h7;
  localparam int          REG_W          = 11;

  // Reset values of the three registers
  localparam logic [10:0] OCP_CTRL_RESET = 11'h169;
  localparam logic [10:0] CSA_CTRL_RESET = 11'h283;
  localparam logic [10:0] DRV_CFG_RESET  = 11'h000;

  // Clock rate and documented times
  localparam int CLK_MHZ        = 250;
  localparam int DEAD_NS_0      = 50;
  localparam int DEAD_NS_1      = 100;
  localparam int DEAD_NS_2      = 200;
  localparam int DEAD_NS_3      = 400;
  localparam int DEG_US_0       = 1;
  localparam int DEG_US_1       = 2;
  localparam int DEG_US_2       = 4;
  localparam int DEG_US_3       = 8;
  localparam int RETRY_LONG_MS  = 8;
  localparam int RETRY_SHORT_US = 50;

  // Least times round up, never below one cycle
  function automatic int ns_to_cyc_up(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int DEAD_CYC_0      = ns_to_cyc_up(DEAD_NS_0);
  localparam int DEAD_CYC_1      = ns_to_cyc_up(DEAD_NS_1);
  localparam int DEAD_CYC_2      = ns_to_cyc_up(DEAD_NS_2);
  localparam int DEAD_CYC_3      = ns_to_cyc_up(DEAD_NS_3);
  localparam int DEG_CYC_0       = ns_to_cyc_up(DEG_US_0 * 1000);
  localparam int DEG_CYC_1       = ns_to_cyc_up(DEG_US_1 * 1000);
  localparam int DEG_CYC_2       = ns_to_cyc_up(DEG_US_2 * 1000);
  localparam int DEG_CYC_3       = ns_to_cyc_up(DEG_US_3 * 1000);
  localparam int RETRY_LONG_CYC  = ns_to_cyc_up(RETRY_LONG_MS * 1000000);
  localparam int RETRY_SHORT_CYC = ns_to_cyc_up(RETRY_SHORT_US * 1000);
  localparam int RETRY_W         = 22;
  localparam int DEG_W           = 11;
  localparam int DEAD_W          = 8;

  typedef enum logic [1:0] {
    OCP_LATCH  = 2'b00,
    OCP_RETRY  = 2'b01,
    OCP_REPORT = 2'b10,
    OCP_IGNORE = 2'b11
  } gdpsr_mode_type;

  typedef enum logic [1:0] {
    ST_CLEAR   = 2'b00,
    ST_LATCHED = 2'b01,
    ST_RETRY   = 2'b10
  } gdpsr_state_type;

  // Field layouts, most significant bit first, bit 10 down to bit 0
  typedef struct packed {
    logic           retry_interval_sel;
    logic [1:0]     dead_time_sel;
    gdpsr_mode_type overcurrent_response;
    logic [1:0]     overcurrent_filter;
    logic [3:0]     drain_source_trip_level;
  } gdpsr_ocp_type;

  typedef struct packed {
    logic       amp_input_select;
    logic       ref_halve;
    logic       low_side_sense_path;
    logic [1:0] amp_gain_sel;
    logic       shunt_trip_disable;
    logic       amp_a_zero;
    logic       amp_b_zero;
    logic       amp_c_zero;
    logic [1:0] shunt_trip_level;
  } gdpsr_csa_type;

  typedef struct packed {
    logic [9:0] reserved;
    logic       cal_auto;
  } gdpsr_cfg_type;

endpackage

// file: rtl/gdpsr_deglitch.sv
// Persistence filter for one raw overcurrent comparator level
`timescale 1ns/100ps
module gdpsr_deglitch (
  input  wire logic                      ref_clk,
  input  wire logic                      arst_n,
  input  wire logic                      raw,
  input  wire logic [gdpsr_pkg::DEG_W-1:0] hold_cycles,
  output logic                           filtered
);

  logic [gdpsr_pkg::DEG_W-1:0] count;

  // Any drop of the level restarts the wait
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (!raw) begin
      count <= '0;
    end else if (count < hold_cycles) begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      filtered <= 1'b0;
    end else begin
      filtered <= raw && (count >= hold_cycles - 1'b1);
    end
  end

endmodule // gdpsr_deglitch

// file: rtl/gdpsr_regs.sv
// Protection and sense-amplifier configuration registers with fault policy
`timescale 1ns/100ps

// How it works
// R1: Response 00b latches an overcurrent fault; 01b clears it after retry time.
// R2: Response 10b only reports; 11b neither reports nor acts.
// R3: Retry-interval bit picks 8 ms when clear, 50 us when set; resets clear.
// R4: Dead-time code selects 50, 100, 200 or 400 ns; default 100 ns.
// R5: Filter code sets overcurrent persistence of 1, 2, 4 or 8 us.
// R6: Setting amplifier input select forces the low-side sense path bit to one.
// R7: Low-side sense path bit picks shunt positive or negative pin reference.
// R8: Reference-halve bit picks full or half reference; resets set.
// R9: Gain code selects 5, 10, 20 or 40 V/V; default 20 V/V.
// R10: Shunt-trip disable bit suppresses the sense overcurrent fault.
// R11: Each amplifier zero bit shorts that amplifier's inputs for calibration.
// R12: Shunt-trip level code sets 0.25, 0.5, 0.75 or 1 V; default 1 V.
// R13: Calibration method bit picks manual when clear, automatic when set.
// R14: Sense and driver configuration registers exist only with sense amplifiers.
// R15: Overcurrent control at 0x05 and sense control at 0x06, both read/write.
// R16: Pulse release applies only in retry mode: new PWM or retry clears fault.
// R17: Fault-clear command clears latched faults and is a self-clearing pulse.
// R18: While the write guard is locked, register writes here are ignored.
// R19: Trip level passes unchanged to comparators; reserved bits read back.
module gdpsr_regs #(
  parameter bit HAS_SENSE_AMPS     = 1'b1,
  parameter int RETRY_LONG_CYCLES  = gdpsr_pkg::RETRY_LONG_CYC,
  parameter int RETRY_SHORT_CYCLES = gdpsr_pkg::RETRY_SHORT_CYC
) (
  input  wire logic                          ref_clk,
  input  wire logic                          arst_n,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic [3:0]                    reg_addr,
  input  wire logic [10:0]                   reg_wdata,
  output logic      [10:0]                   reg_rdata,
  output logic                               reg_rvalid,
  input  wire logic                          regs_locked,
  input  wire logic                          fault_clear_cmd,
  input  wire logic                          pulse_release_enable,
  input  wire logic                          pwm_edge,
  input  wire logic                          drain_source_overcurrent,
  input  wire logic                          shunt_overcurrent,
  output gdpsr_pkg::gdpsr_ocp_type           ocp_cfg,
  output gdpsr_pkg::gdpsr_csa_type           csa_cfg,
  output logic                               cal_auto_run,
  output logic      [gdpsr_pkg::DEAD_W-1:0]  dead_time_cycles,
  output logic      [gdpsr_pkg::DEG_W-1:0]   filter_cycles,
  output logic                               shunt_trip_enable,
  output logic                               overcurrent_reported,
  output logic                               gate_shutdown,
  output logic                               ds_fault_flag,
  output logic                               shunt_fault_flag
);

  gdpsr_pkg::gdpsr_cfg_type              drv_cfg;
  gdpsr_pkg::gdpsr_csa_type              next_csa;
  gdpsr_pkg::gdpsr_state_type            state;
  gdpsr_pkg::gdpsr_state_type            next_state;
  logic [gdpsr_pkg::RETRY_W-1:0]         retry_count;
  logic [gdpsr_pkg::RETRY_W-1:0]         retry_load;
  logic                                  write_ok;
  logic                                  ds_raw;
  logic                                  shunt_raw;
  logic                                  ds_filtered;
  logic                                  shunt_filtered;
  logic                                  oc_detect;
  logic                                  mode_acts;
  logic                                  retry_done;
  logic                                  retry_exit;

  function automatic logic [gdpsr_pkg::DEAD_W-1:0] dead_lookup(
    input logic [1:0] sel
  );
    case (sel)
      2'b00:   return gdpsr_pkg::DEAD_W'(gdpsr_pkg::DEAD_CYC_0);
      2'b01:   return gdpsr_pkg::DEAD_W'(gdpsr_pkg::DEAD_CYC_1);
      2'b10:   return gdpsr_pkg::DEAD_W'(gdpsr_pkg::DEAD_CYC_2);
      default: return gdpsr_pkg::DEAD_W'(gdpsr_pkg::DEAD_CYC_3);
    endcase
  endfunction

  function automatic logic [gdpsr_pkg::DEG_W-1:0] deg_lookup(
    input logic [1:0] sel
  );
    case (sel)
      2'b00:   return gdpsr_pkg::DEG_W'(gdpsr_pkg::DEG_CYC_0);
      2'b01:   return gdpsr_pkg::DEG_W'(gdpsr_pkg::DEG_CYC_1);
      2'b10:   return gdpsr_pkg::DEG_W'(gdpsr_pkg::DEG_CYC_2);
      default: return gdpsr_pkg::DEG_W'(gdpsr_pkg::DEG_CYC_3);
    endcase
  endfunction

  // Register writes
  // Lock field lives elsewhere, so the guard only blocks writes here
  assign write_ok = reg_wr && !regs_locked; // [R18]

  // Forced on the way in, so a read shows the forced bit
  always_comb begin
    next_csa = gdpsr_pkg::gdpsr_csa_type'(reg_wdata);
    if (next_csa.amp_input_select) begin
      next_csa.low_side_sense_path = 1'b1; // [R6]
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ocp_cfg <= gdpsr_pkg::gdpsr_ocp_type'(gdpsr_pkg::OCP_CTRL_RESET);
    end else if (write_ok && reg_addr == gdpsr_pkg::ADDR_OCP_CTRL) begin
      ocp_cfg <= gdpsr_pkg::gdpsr_ocp_type'(reg_wdata); // [R15] [R19]
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      csa_cfg <= gdpsr_pkg::gdpsr_csa_type'(gdpsr_pkg::CSA_CTRL_RESET); // [R8]
    end else if (HAS_SENSE_AMPS && write_ok &&
                 reg_addr == gdpsr_pkg::ADDR_CSA_CTRL) begin // [R14]
      csa_cfg <= next_csa; // [R15]
    end
  end

  // Reserved bits keep what was written so software sees its own value
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      drv_cfg <= gdpsr_pkg::gdpsr_cfg_type'(gdpsr_pkg::DRV_CFG_RESET);
    end else if (HAS_SENSE_AMPS && write_ok &&
                 reg_addr == gdpsr_pkg::ADDR_DRV_CFG) begin // [R14]
      drv_cfg <= gdpsr_pkg::gdpsr_cfg_type'(reg_wdata); // [R19]
    end
  end

  // Register reads, one cycle after the strobe; absent addresses read zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        gdpsr_pkg::ADDR_OCP_CTRL: reg_rdata <= ocp_cfg; // [R15]
        gdpsr_pkg::ADDR_CSA_CTRL:
          reg_rdata <= HAS_SENSE_AMPS ? csa_cfg : '0; // [R14]
        gdpsr_pkg::ADDR_DRV_CFG:
          reg_rdata <= HAS_SENSE_AMPS ? drv_cfg : '0; // [R14]
        default:                  reg_rdata <= '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  // Settings handed to the analog side, all from flops
  // Registered so the analog side never sees a decode glitch
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dead_time_cycles <= '0;
      filter_cycles    <= '0;
    end else begin
      dead_time_cycles <= dead_lookup(ocp_cfg.dead_time_sel); // [R4]
      filter_cycles    <= deg_lookup(ocp_cfg.overcurrent_filter); // [R5]
    end
  end

  // Gain, reference, sense path, zero bits and level go out as csa_cfg
  // Sense path picks the low-side compare reference pin [R7]
  // Gain code reaches the amplifiers unchanged [R9]
  // Zero bits short the amplifier inputs while set [R11]
  // Level code sets the sense comparator threshold [R12]
  assign cal_auto_run      = HAS_SENSE_AMPS && drv_cfg.cal_auto; // [R13]
  assign shunt_trip_enable = HAS_SENSE_AMPS &&
                             !csa_cfg.shunt_trip_disable; // [R10]

  // Overcurrent detection
  assign mode_acts = ocp_cfg.overcurrent_response != gdpsr_pkg::OCP_IGNORE;
  assign ds_raw    = drain_source_overcurrent && mode_acts; // [R2]
  assign shunt_raw = shunt_overcurrent && shunt_trip_enable &&
                     mode_acts; // [R10]

  // One filter per comparator so one path cannot mask the other
  // Both share one length; each restarts on its own level drop
  gdpsr_deglitch u_ds_filter (
    .ref_clk     (ref_clk),
    .arst_n      (arst_n),
    .raw         (ds_raw),
    .hold_cycles (filter_cycles),
    .filtered    (ds_filtered)
  ); // [R5]

  gdpsr_deglitch u_shunt_filter (
    .ref_clk     (ref_clk),
    .arst_n      (arst_n),
    .raw         (shunt_raw),
    .hold_cycles (filter_cycles),
    .filtered    (shunt_filtered)
  ); // [R5]

  assign oc_detect = ds_filtered || shunt_filtered;

  // Sticky flags; a new event in the clearing cycle wins over the clear
  // Report mode sets them too; only ignore mode keeps them quiet
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ds_fault_flag <= 1'b0;
    end else if (ds_filtered) begin
      ds_fault_flag <= 1'b1;
    end else if (fault_clear_cmd) begin
      ds_fault_flag <= 1'b0; // [R17]
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      shunt_fault_flag <= 1'b0;
    end else if (shunt_filtered) begin
      shunt_fault_flag <= 1'b1;
    end else if (fault_clear_cmd) begin
      shunt_fault_flag <= 1'b0; // [R17]
    end
  end

  // Fault state machine
  // One short, since the entry edge already spends a cycle
  assign retry_load = (ocp_cfg.retry_interval_sel ?
                       gdpsr_pkg::RETRY_W'(RETRY_SHORT_CYCLES) :
                       gdpsr_pkg::RETRY_W'(RETRY_LONG_CYCLES)) -
                      1'b1; // [R3]
  assign retry_done = retry_count == '0;
  assign retry_exit = retry_done ||
                      (pulse_release_enable && pwm_edge); // [R16]

  always_comb begin
    next_state = state;
    case (state)
      gdpsr_pkg::ST_CLEAR: begin
        if (oc_detect) begin
          case (ocp_cfg.overcurrent_response)
            gdpsr_pkg::OCP_LATCH: next_state = gdpsr_pkg::ST_LATCHED; // [R1]
            gdpsr_pkg::OCP_RETRY: next_state = gdpsr_pkg::ST_RETRY; // [R1]
            default:              next_state = gdpsr_pkg::ST_CLEAR; // [R2]
          endcase
        end
      end
      gdpsr_pkg::ST_LATCHED: begin
        // Report and ignore modes never hold the gates off
        // Clear loses to a persisting overcurrent
        if (ocp_cfg.overcurrent_response[1]) begin
          next_state = gdpsr_pkg::ST_CLEAR; // [R2]
        end else if (fault_clear_cmd && !oc_detect) begin
          next_state = gdpsr_pkg::ST_CLEAR; // [R17]
        end
      end
      gdpsr_pkg::ST_RETRY: begin
        // A switch to latch mode keeps the gates off until cleared
        if (ocp_cfg.overcurrent_response == gdpsr_pkg::OCP_LATCH) begin
          next_state = gdpsr_pkg::ST_LATCHED; // [R1]
        end else if (ocp_cfg.overcurrent_response !=
                     gdpsr_pkg::OCP_RETRY) begin
          next_state = gdpsr_pkg::ST_CLEAR; // [R16]
        end else if (retry_exit && !oc_detect) begin
          next_state = gdpsr_pkg::ST_CLEAR; // [R1] [R16]
        end
      end
      default: next_state = gdpsr_pkg::ST_CLEAR;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= gdpsr_pkg::ST_CLEAR;
    end else begin
      state <= next_state;
    end
  end

  // Retry timer restarts while the condition still stands at expiry
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      retry_count <= '0;
    end else if (next_state == gdpsr_pkg::ST_RETRY &&
                 (state != gdpsr_pkg::ST_RETRY || retry_exit)) begin
      retry_count <= retry_load; // [R3]
    end else if (state == gdpsr_pkg::ST_RETRY && !retry_done) begin
      retry_count <= retry_count - 1'b1;
    end
  end

  // Gates go off from the edge after the filtered event
  assign gate_shutdown = state != gdpsr_pkg::ST_CLEAR; // [R1]

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      overcurrent_reported <= 1'b0;
    end else begin
      // Latch and retry report for as long as the gates are held off
      overcurrent_reported <= mode_acts &&
        (next_state != gdpsr_pkg::ST_CLEAR ||
         (ocp_cfg.overcurrent_response == gdpsr_pkg::OCP_REPORT &&
          oc_detect)); // [R2]
    end
  end

endmodule // gdpsr_regs

// file: tb/gdpsr_props.sv
// Port-level checker for the protect/sense register block
`timescale 1ns/100ps
module gdpsr_props #(
  parameter bit HAS_SENSE_AMPS = 1'b1
) (
  input wire logic                     ref_clk,
  input wire logic                     arst_n,
  input wire logic                     reg_wr,
  input wire logic                     reg_rd,
  input wire logic [3:0]               reg_addr,
  input wire logic [10:0]              reg_wdata,
  input wire logic                     reg_rvalid,
  input wire logic                     regs_locked,
  input wire logic                     fault_clear_cmd,
  input wire logic                     drain_source_overcurrent,
  input wire logic                     shunt_overcurrent,
  input wire gdpsr_pkg::gdpsr_ocp_type ocp_cfg,
  input wire gdpsr_pkg::gdpsr_csa_type csa_cfg,
  input wire logic [7:0]               dead_time_cycles,
  input wire logic [10:0]              filter_cycles,
  input wire logic                     shunt_trip_enable,
  input wire logic                     gate_shutdown,
  input wire logic                     ds_fault_flag
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  // Dead time rounds up, so no clean shift
  function automatic logic [7:0] dt(input logic [1:0] s);
    return s[1] ? (s[0] ? 8'h64 : 8'h32) : (s[0] ? 8'h19 : 8'h0D);
  endfunction

  // Raw levels low long enough for the filter to have dropped
  sequence quiet3;
    (!drain_source_overcurrent && !shunt_overcurrent) [*3];
  endsequence
  sequence clear_latch;
    quiet3 ##0 (fault_clear_cmd && ocp_cfg.overcurrent_response == 2'b00);
  endsequence

  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  wr_take_a: assert property (
    reg_wr && reg_addr == 4'h5 && !regs_locked |=> ocp_cfg == $past(reg_wdata))
    else $error("write not taken");
  lock_hold_a: assert property (
    regs_locked && reg_wr |=> $stable(ocp_cfg) && $stable(csa_cfg))
    else $error("write taken while locked");
  fet_ref_a: assert property (
    csa_cfg.amp_input_select |-> csa_cfg.low_side_sense_path)
    else $error("sense path not forced");
  dead_map_a: assert property (
    $past(arst_n) |-> dead_time_cycles == dt($past(ocp_cfg.dead_time_sel)))
    else $error("dead time wrong");
  filt_map_a: assert property ($past(arst_n) |->
    filter_cycles == (11'h0FA << $past(ocp_cfg.overcurrent_filter)))
    else $error("filter length wrong");
  shunt_en_a: assert property (
    shunt_trip_enable == (HAS_SENSE_AMPS && !csa_cfg.shunt_trip_disable))
    else $error("shunt enable wrong");
  quiet_mode_a: assert property (
    ocp_cfg.overcurrent_response[1] [*3] |-> !gate_shutdown)
    else $error("shutdown in report or ignore mode");
  latch_hold_a: assert property (ocp_cfg.overcurrent_response == 2'b00
    && gate_shutdown && !fault_clear_cmd && !reg_wr |=> gate_shutdown)
    else $error("latched fault dropped");
  clear_drop_a: assert property (
    clear_latch |=> !gate_shutdown && !ds_fault_flag)
    else $error("clear command ignored");
endmodule // gdpsr_props

bind gdpsr_regs gdpsr_props #(.HAS_SENSE_AMPS(HAS_SENSE_AMPS)) u_props (.*);

// file: tb/gdpsr_host_model.sv
// Controller-side model of the register port and fault clear
`timescale 1ns/100ps
module gdpsr_host_model (
  input  wire logic        ref_clk,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [3:0]       reg_addr,
  output logic [10:0]      reg_wdata,
  input  wire logic [10:0] reg_rdata,
  input  wire logic        reg_rvalid,
  output logic             fault_clear_cmd
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 11'h000;
    fault_clear_cmd = 1'b0;
  end
  // Leading wait keeps back-to-back calls off one time step
  task automatic wr(input logic [3:0] a, input logic [10:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d; // Idle data must not echo the last word
  endtask
  task automatic rd(input logic [3:0] a, output logic [10:0] d);
    int k;
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    for (k = 0; k < 4 && reg_rvalid !== 1'b1; k++) begin
      @(posedge ref_clk);
      #1;
    end
    d = (reg_rvalid === 1'b1) ? reg_rdata : 'x;
  endtask
  task automatic clr();
    @(posedge ref_clk);
    #1;
    fault_clear_cmd = 1'b1;
    @(posedge ref_clk);
    #1;
    fault_clear_cmd = 1'b0;
  endtask
endmodule // gdpsr_host_model

// file: tb/gdpsr_regs_tb_top.sv
// Self-checking bench for the protect/sense register block
`timescale 1ns/100ps
module gdpsr_regs_tb_top;
  localparam int RL = 40;
  localparam int RS = 10;
  logic        ref_clk, arst_n, reg_wr, reg_rd, reg_rvalid, regs_locked;
  logic        fault_clear_cmd, pulse_release_enable, pwm_edge, cal_auto_run;
  logic        drain_source_overcurrent, shunt_overcurrent, shunt_trip_enable;
  logic        overcurrent_reported, gate_shutdown, ds_fault_flag;
  logic        shunt_fault_flag;
  logic [3:0]  reg_addr;
  logic [7:0]  dead_time_cycles;
  logic [10:0] reg_wdata, reg_rdata, filter_cycles, v;
  gdpsr_pkg::gdpsr_ocp_type ocp_cfg;
  gdpsr_pkg::gdpsr_csa_type csa_cfg;
  int          n_mismatch = 0, num_checks = 0, cyc = 0, n;

  gdpsr_regs #(.RETRY_LONG_CYCLES(RL), .RETRY_SHORT_CYCLES(RS)) dut (.*);
  gdpsr_host_model host (.*);

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic check(input string w, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", w, e, s);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_gate(input logic lvl);
    n = 0;
    while (gate_shutdown !== lvl && n < 400) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask

  task automatic test_reset();
    host.rd(4'h5, v);
    check("ocp reset", v, 11'h169);
    host.rd(4'h6, v);
    check("csa reset", v, 11'h283);
    host.rd(4'h7, v);
    check("cfg reset", v, 11'h000);
    check("dead reset", dead_time_cycles, 8'h19);
    $display("test_reset done");
  endtask
  task automatic test_fields();
    logic [1:0] k;
    for (int c = 0; c < 4; c++) begin
      k = 2'(c);
      host.wr(4'h5, {k[0], k, 2'b01, k, k, k});
      host.rd(4'h5, v);
      check("ocp rw", v, {k[0], k, 2'b01, k, k, k});
      check("trip lvl", ocp_cfg.drain_source_trip_level, {k, k});
      host.wr(4'h6, {2'b01, 1'b0, k, 4'h0, k});
      host.rd(4'h6, v);
      check("csa rw", v, {2'b01, 1'b0, k, 4'h0, k});
    end
    check("dead max", dead_time_cycles, 8'h64);
    check("filter max", filter_cycles, 11'h7D0);
    host.wr(4'h6, 11'h400);
    host.rd(4'h6, v);
    check("fet ref", v, 11'h500);
    host.wr(4'h6, 11'h100);
    host.rd(4'h6, v);
    check("ls path", v, 11'h100);
    host.wr(4'h6, 11'h2BC);
    host.rd(4'h6, v);
    check("cal bits", v, 11'h2BC);
    check("shunt off", shunt_trip_enable, 1'b0);
    host.wr(4'h7, 11'h7FF);
    host.rd(4'h7, v);
    check("cfg rw", v, 11'h7FF);
    check("auto cal", cal_auto_run, 1'b1);
    host.wr(4'hA, 11'h7FF);
    host.rd(4'hA, v);
    check("unmapped", v, 11'h000);
    host.wr(4'h6, 11'h283);
    host.wr(4'h7, 11'h000);
    regs_locked = 1'b1;
    host.wr(4'h5, 11'h000);
    host.rd(4'h5, v);
    check("locked", v, 11'h77F);
    regs_locked = 1'b0;
    $display("test_fields done");
  endtask
  task automatic test_latch();
    host.wr(4'h5, 11'h109);
    drain_source_overcurrent = 1'b1;
    wait_gate(1'b1);
    check("deglitch", n >= 250 && n <= 256, 1'b1);
    check("latch", {overcurrent_reported, ds_fault_flag}, 2'b11);
    drain_source_overcurrent = 1'b0;
    tick(20);
    check("latch stays", gate_shutdown, 1'b1);
    host.clr();
    tick(1);
    check("cleared", {gate_shutdown, ds_fault_flag}, 2'b00);
    $display("test_latch done");
  endtask
  task automatic test_retry();
    int t;
    for (int s = 1; s >= 0; s--) begin
      t = s ? RS : RL;
      host.wr(4'h5, s ? 11'h549 : 11'h149);
      drain_source_overcurrent = 1'b1;
      wait_gate(1'b1);
      drain_source_overcurrent = 1'b0;
      wait_gate(1'b0);
      check("retry len", n >= t - 2 && n <= t + 4, 1'b1);
    end
    pulse_release_enable = 1'b1;
    drain_source_overcurrent = 1'b1;
    wait_gate(1'b1);
    drain_source_overcurrent = 1'b0;
    tick(3);
    pwm_edge = 1'b1;
    tick(1);
    pwm_edge = 1'b0;
    tick(2);
    check("pwm release", gate_shutdown, 1'b0);
    pulse_release_enable = 1'b0;
    $display("test_retry done");
  endtask
  task automatic test_report();
    host.clr();
    host.wr(4'h5, 11'h189);
    drain_source_overcurrent = 1'b1;
    tick(270);
    check("report", {overcurrent_reported, gate_shutdown}, 2'b10);
    drain_source_overcurrent = 1'b0;
    tick(4);
    check("report drop", overcurrent_reported, 1'b0);
    host.clr();
    host.wr(4'h5, 11'h1C9);
    drain_source_overcurrent = 1'b1;
    tick(270);
    check("silent", {overcurrent_reported, ds_fault_flag}, 2'b00);
    drain_source_overcurrent = 1'b0;
    $display("test_report done");
  endtask
  task automatic test_shunt();
    host.wr(4'h5, 11'h109);
    host.wr(4'h6, 11'h2A3);
    shunt_overcurrent = 1'b1;
    tick(270);
    check("shunt masked", gate_shutdown, 1'b0);
    host.wr(4'h6, 11'h283);
    tick(270);
    check("shunt trip", {gate_shutdown, shunt_fault_flag}, 2'b11);
    shunt_overcurrent = 1'b0;
    tick(3);
    host.clr();
    tick(1);
    check("shunt clear", {gate_shutdown, shunt_fault_flag}, 2'b00);
    $display("test_shunt done");
  endtask

  // Whole run is a few thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end

  initial begin
    arst_n = 1'b0;
    regs_locked = 1'b0;
    pulse_release_enable = 1'b0;
    pwm_edge = 1'b0;
    drain_source_overcurrent = 1'b0;
    shunt_overcurrent = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    test_reset();
    test_fields();
    test_latch();
    test_retry();
    test_report();
    test_shunt();
    results();
  end
endmodule // gdpsr_regs_tb_top
